// ---- cwd_pkg.sv ----
// package for the configuration word decoder: offsets, field positions, reset values, codes
package cwd_pkg;
	// register byte addresses on the avalon slave
	localparam logic [3:0] OFS_WORD_TWO = 4'h0;
	localparam logic [3:0] OFS_WORD_THREE = 4'h4;
	localparam logic [3:0] OFS_WORD_FOUR = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	localparam logic [3:0] OFS_LOCK_CTRL = 4'h0;
	localparam logic [3:0] OFS_UNLOCK = 4'h4;
	// unlock sequence keys
	localparam logic [7:0] UNLOCK_KEY_A = 8'h46;
	localparam logic [7:0] UNLOCK_KEY_B = 8'h57;
	localparam logic [7:0] FILL_UPPER = 8'hFF;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	localparam logic [23:0] WORD_RESET = 24'hFF_FFFF;
	// word two field positions
	localparam int W2_MUX_EN = 13;
	localparam int W2_CKSM_HI = 7;
	localparam int W2_CKSM_LO = 6;
	localparam int W2_PIN_FN = 5;
	localparam int W2_WDCLK_HI = 4;
	localparam int W2_WDCLK_LO = 3;
	localparam int W2_POSC_HI = 1;
	localparam int W2_POSC_LO = 0;
	// word three field positions
	localparam int W3_END_SEL = 15;
	localparam int W3_CFG_PROT = 14;
	localparam int W3_SEG_DIS = 13;
	localparam int W3_BOR_EN = 12;
	localparam int W3_WIN_HI = 10;
	localparam int W3_WIN_LO = 9;
	localparam int W3_SECONDARY_OSC_SEL = 8;
	localparam int W3_PAGE_HI = 6;
	localparam int W3_PAGE_LO = 0;
	// word four field positions
	localparam int W4_ONE_WAY = 15;
	localparam int W4_I2C_LOC = 14;
	localparam int W4_PLL_HI = 13;
	localparam int W4_PLL_LO = 10;
	localparam int W4_RTC_BAT = 9;
	localparam int W4_DS_SW = 8;
	localparam int W4_DS_WDT = 7;
	// flash geometry
	localparam int PAGE_WORDS = 512;
	localparam logic [23:0] FLASH_BASE = 24'h00_0000;
	// watchdog clock sources
	typedef enum logic [1:0] {CWD_WDCLK_LOW_POWER_RC_OSC, CWD_WDCLK_FRC, CWD_WDCLK_SECONDARY_OSC, CWD_WDCLK_SYS} cwd_wdclk_e;
	// primary oscillator modes
	typedef enum logic [1:0] {CWD_POSC_EC, CWD_POSC_XT, CWD_POSC_HS, CWD_POSC_OFF} cwd_posc_e;
	// window widths in eighths of the period
	localparam logic [3:0] WIN_25 = 4'h2;
	localparam logic [3:0] WIN_37 = 4'h3;
	localparam logic [3:0] WIN_50 = 4'h4;
	localparam logic [3:0] WIN_75 = 4'h6;
	localparam logic [3:0] PLL_OFF_CODE = 4'hF;
endpackage

// ---- cwd_pin_lock.sv ----
// pin-select lock with unlock sequence and one-way policy
`timescale 1ns/100ps
module cwd_pin_lock (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic one_way, // lock may be set only once
	input wire logic key_wr, // unlock key write strobe
	input wire logic [7:0] key_data, // unlock key value
	input wire logic lock_wr, // lock bit write strobe
	input wire logic lock_data, // requested lock bit value
	output logic pin_select_lock, // pin-select registers locked
	output logic unlocked // unlock sequence completed
);
	logic key_a_ff;
	logic unlocked_ff;
	logic lock_ff;
	logic set_once_ff;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			key_a_ff <= 1'b0;
			unlocked_ff <= 1'b0;
		end
		else if (key_wr)
		begin
			key_a_ff <= (key_data == cwd_pkg::UNLOCK_KEY_A);
			unlocked_ff <= key_a_ff && (key_data == cwd_pkg::UNLOCK_KEY_B);
		end
		else if (lock_wr)
		begin
			// each lock change consumes the sequence
			key_a_ff <= 1'b0;
			unlocked_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lock_ff <= 1'b0;
			set_once_ff <= 1'b0;
		end
		else if (lock_wr && unlocked_ff)
		begin
			if (one_way)
			begin
				if (!set_once_ff && lock_data)
				begin
					lock_ff <= 1'b1;
					set_once_ff <= 1'b1;
				end
			end
			else
				lock_ff <= lock_data;
		end
	end

	assign pin_select_lock = lock_ff;
	assign unlocked = unlocked_ff;
endmodule

// ---- cwd_config_decoder.sv ----
// configuration word decoder: latches words on the first clock after reset, decodes static controls
`timescale 1ns/100ps
module cwd_config_decoder #(
	parameter int PAGE_W = 7, // width of the boundary page field
	parameter logic [6:0] LAST_PAGE = 7'h57, // page holding the config words
	parameter bit LARGE_PIN_PART = 1'b1, // larger-pin variant
	parameter bit LARGE_MEM_PART = 1'b1 // larger memory variant
) (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [23:0] nv_word_two, // stored word two
	input wire logic [23:0] nv_word_three, // stored word three
	input wire logic [23:0] nv_word_four, // stored word four
	input wire logic in_sleep, // device in sleep
	input wire logic windowed_wdt, // windowed watchdog mode selected
	input wire logic low_power_rc_osc_is_sysclk, // low-power RC drives system clock
	input wire logic sw_deep_sleep_request, // software deep-sleep enable bit
	input wire logic [3:0] avs_address, // avalon byte address
	input wire logic avs_read, // avalon read
	input wire logic avs_write, // avalon write
	input wire logic [31:0] avs_writedata, // avalon write data
	input wire logic [3:0] avs_byteenable, // avalon byte enables
	input wire logic avs_chipselect_lock, // selects the lock register pair
	output logic [31:0] avs_readdata, // avalon read data
	output logic avs_waitrequest, // avalon wait request
	output logic clock_switch_en, // clock switching allowed
	output logic fail_safe_monitor_en, // fail-safe clock monitor on
	output logic osc_pin_clock_output, // pin carries system clock / 2
	output logic osc_pin_port_io, // pin acts as port I/O
	output logic [1:0] watchdog_clock_src, // cwd_wdclk_e code
	output logic [1:0] primary_osc_mode, // cwd_posc_e code
	output logic crystal_high_speed, // high-speed crystal drive
	output logic flash_protect_en, // segment protection active
	output logic [23:0] protect_lo_addr, // lowest protected word address
	output logic [23:0] protect_hi_addr, // highest protected word address
	output logic config_page_protected, // last page write-protected
	output logic brownout_reset_en, // brown-out reset outside deep sleep
	output logic [3:0] watchdog_window_eighths, // window width in eighths
	output logic secondary_osc_crystal, // crystal circuit enabled
	output logic secondary_clock_digital_in, // digital clock input mode
	output logic second_i2c_alt_pins, // alternate i2c pin pair
	output logic usb_pll_enable, // usb pll running
	output logic [3:0] usb_pll_divisor, // oscillator divisor
	output logic usb_pll_code_reserved, // reserved prescale code stored
	output logic battery_rtc_run, // rtc runs in battery mode
	output logic deep_sleep_allowed, // deep sleep permitted now
	output logic deep_sleep_watchdog_enable, // deep-sleep watchdog on
	output logic pin_select_lock // pin-select registers locked
);
	logic [23:0] word_two_ff;
	logic [23:0] word_three_ff;
	logic [23:0] word_four_ff;
	logic load_pending_ff;
	logic rd_ack_ff;
	logic [31:0] rd_data_ff;
	logic [31:0] nxt_rd_data;
	logic [1:0] cksm;
	logic [1:0] posc;
	logic [1:0] wdclk;
	logic [1:0] win;
	logic [3:0] pll;
	logic [PAGE_W-1:0] page;
	logic key_wr;
	logic lock_wr;
	logic unlocked;
	logic [23:0] page_base;
	logic [23:0] last_base;

	// a reset is the only way in; the words must not track the pins at run time
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			load_pending_ff <= 1'b1;
		else
			load_pending_ff <= 1'b0;
	end

	// strap capture happens on the first edge after release, never under reset
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			word_two_ff <= cwd_pkg::WORD_RESET;
			word_three_ff <= cwd_pkg::WORD_RESET;
			word_four_ff <= cwd_pkg::WORD_RESET;
		end
		else if (load_pending_ff)
		begin
			word_two_ff <= {cwd_pkg::FILL_UPPER, nv_word_two[15:0]};
			word_three_ff <= {cwd_pkg::FILL_UPPER, nv_word_three[15:0]};
			word_four_ff <= {cwd_pkg::FILL_UPPER, nv_word_four[15:0]};
		end
	end

	// held unchanged until the next reset; no bus write reaches them
	assign cksm = word_two_ff[cwd_pkg::W2_CKSM_HI:cwd_pkg::W2_CKSM_LO];
	assign posc = word_two_ff[cwd_pkg::W2_POSC_HI:cwd_pkg::W2_POSC_LO];
	assign wdclk = word_two_ff[cwd_pkg::W2_WDCLK_HI:cwd_pkg::W2_WDCLK_LO];
	assign win = word_three_ff[cwd_pkg::W3_WIN_HI:cwd_pkg::W3_WIN_LO];
	assign pll = word_four_ff[cwd_pkg::W4_PLL_HI:cwd_pkg::W4_PLL_LO];

	// the small memory part ignores the top page bit
	always_comb
	begin
		page = word_three_ff[cwd_pkg::W3_PAGE_HI:cwd_pkg::W3_PAGE_LO];
		if (!LARGE_MEM_PART)
			page[PAGE_W-1] = 1'b0;
	end

	assign clock_switch_en = !cksm[1];
	assign fail_safe_monitor_en = (cksm == 2'b00);

	// pin function bit only counts in disabled or external clock modes
	assign osc_pin_clock_output = (posc == 2'b11 || posc == 2'b00) &&
		word_two_ff[cwd_pkg::W2_PIN_FN];
	assign osc_pin_port_io = (posc == 2'b11 || posc == 2'b00) &&
		!word_two_ff[cwd_pkg::W2_PIN_FN];

	always_comb
	begin
		if (!word_two_ff[cwd_pkg::W2_MUX_EN])
			watchdog_clock_src = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
		else
		begin
			case (wdclk)
				2'b11: watchdog_clock_src = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
				2'b10:
				begin
					if (windowed_wdt && !low_power_rc_osc_is_sysclk && !in_sleep)
						watchdog_clock_src = cwd_pkg::CWD_WDCLK_FRC;
					else
						watchdog_clock_src = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
				end
				2'b01: watchdog_clock_src = cwd_pkg::CWD_WDCLK_SECONDARY_OSC;
				2'b00: watchdog_clock_src = in_sleep ? cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC :
					cwd_pkg::CWD_WDCLK_SYS;
				default: watchdog_clock_src = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
			endcase
		end
	end

	always_comb
	begin
		case (posc)
			2'b11: primary_osc_mode = cwd_pkg::CWD_POSC_OFF;
			2'b10: primary_osc_mode = cwd_pkg::CWD_POSC_HS;
			2'b01: primary_osc_mode = cwd_pkg::CWD_POSC_XT;
			2'b00: primary_osc_mode = cwd_pkg::CWD_POSC_EC;
			default: primary_osc_mode = cwd_pkg::CWD_POSC_OFF;
		endcase
	end
	// meant for crystals of 10 MHz and up
	assign crystal_high_speed = (posc == 2'b10);

	// page numbers become word addresses in 512-word steps
	assign page_base = 24'(page) * 24'(cwd_pkg::PAGE_WORDS);
	assign last_base = 24'(LAST_PAGE) * 24'(cwd_pkg::PAGE_WORDS);

	assign flash_protect_en = !word_three_ff[cwd_pkg::W3_SEG_DIS];

	always_comb
	begin
		if (word_three_ff[cwd_pkg::W3_END_SEL])
		begin
			protect_lo_addr = page_base;
			protect_hi_addr = last_base + 24'(cwd_pkg::PAGE_WORDS - 1);
		end
		else
		begin
			protect_lo_addr = cwd_pkg::FLASH_BASE;
			protect_hi_addr = page_base + 24'(cwd_pkg::PAGE_WORDS - 1);
		end
	end

	// the end bit and a boundary on the last page both override the page bit
	assign config_page_protected = flash_protect_en &&
		(!word_three_ff[cwd_pkg::W3_CFG_PROT] ||
		word_three_ff[cwd_pkg::W3_END_SEL] || (page == LAST_PAGE));

	// deep-sleep exclusion is applied by the power logic
	assign brownout_reset_en = word_three_ff[cwd_pkg::W3_BOR_EN];

	always_comb
	begin
		case (win)
			2'b11: watchdog_window_eighths = cwd_pkg::WIN_25;
			2'b10: watchdog_window_eighths = cwd_pkg::WIN_37;
			2'b01: watchdog_window_eighths = cwd_pkg::WIN_50;
			2'b00: watchdog_window_eighths = cwd_pkg::WIN_75;
			default: watchdog_window_eighths = cwd_pkg::WIN_75;
		endcase
	end

	// pin direction in digital mode is software's job
	assign secondary_osc_crystal = word_three_ff[cwd_pkg::W3_SECONDARY_OSC_SEL];
	assign secondary_clock_digital_in = !word_three_ff[cwd_pkg::W3_SECONDARY_OSC_SEL];

	// the small pin part has one fixed pair
	assign second_i2c_alt_pins = LARGE_PIN_PART ?
		word_four_ff[cwd_pkg::W4_I2C_LOC] : 1'b1;

	always_comb
	begin
		usb_pll_enable = 1'b1;
		usb_pll_code_reserved = 1'b0;
		case (pll)
			4'h0: usb_pll_divisor = 4'h1;
			4'h1: usb_pll_divisor = 4'h2;
			4'h2: usb_pll_divisor = 4'h3;
			4'h3: usb_pll_divisor = 4'h4;
			4'h4: usb_pll_divisor = 4'h5;
			4'h5: usb_pll_divisor = 4'h6;
			4'h6: usb_pll_divisor = 4'h8;
			4'h7: usb_pll_divisor = 4'hC;
			cwd_pkg::PLL_OFF_CODE:
			begin
				usb_pll_divisor = 4'h1;
				usb_pll_enable = 1'b0;
			end
			default:
			begin
				// reserved codes keep the pll off rather than guess a ratio
				usb_pll_divisor = 4'h1;
				usb_pll_enable = 1'b0;
				usb_pll_code_reserved = 1'b1;
			end
		endcase
	end

	assign battery_rtc_run = word_four_ff[cwd_pkg::W4_RTC_BAT];
	assign deep_sleep_allowed = word_four_ff[cwd_pkg::W4_DS_SW] &&
		sw_deep_sleep_request;
	assign deep_sleep_watchdog_enable = word_four_ff[cwd_pkg::W4_DS_WDT];

	// lock registers: writes land in one cycle, full-byte lane 0 required
	assign key_wr = avs_write && avs_chipselect_lock && avs_byteenable[0] &&
		(avs_address == cwd_pkg::OFS_UNLOCK);
	assign lock_wr = avs_write && avs_chipselect_lock && avs_byteenable[0] &&
		(avs_address == cwd_pkg::OFS_LOCK_CTRL);

	cwd_pin_lock u_pin_lock (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.one_way(word_four_ff[cwd_pkg::W4_ONE_WAY]),
		.key_wr(key_wr),
		.key_data(avs_writedata[7:0]),
		.lock_wr(lock_wr),
		.lock_data(avs_writedata[0]),
		.pin_select_lock(pin_select_lock),
		.unlocked(unlocked)
	);

	always_comb
	begin
		nxt_rd_data = cwd_pkg::UNMAPPED_READ;
		if (avs_chipselect_lock)
		begin
			case (avs_address)
				cwd_pkg::OFS_LOCK_CTRL: nxt_rd_data = {31'h0, pin_select_lock};
				cwd_pkg::OFS_UNLOCK: nxt_rd_data = {31'h0, unlocked};
				default: nxt_rd_data = cwd_pkg::UNMAPPED_READ;
			endcase
		end
		else
		begin
			case (avs_address)
				cwd_pkg::OFS_WORD_TWO: nxt_rd_data = {8'h00, word_two_ff};
				cwd_pkg::OFS_WORD_THREE: nxt_rd_data = {8'h00, word_three_ff};
				cwd_pkg::OFS_WORD_FOUR: nxt_rd_data = {8'h00, word_four_ff};
				cwd_pkg::OFS_STATUS: nxt_rd_data = {28'h0, usb_pll_code_reserved,
					config_page_protected, flash_protect_en, pin_select_lock};
				default: nxt_rd_data = cwd_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// reads take one wait cycle so data come from a flop
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_ack_ff <= 1'b0;
			rd_data_ff <= 32'h0000_0000;
		end
		else
		begin
			rd_ack_ff <= avs_read && !rd_ack_ff;
			if (avs_read && !rd_ack_ff)
				rd_data_ff <= nxt_rd_data;
		end
	end

	assign avs_readdata = rd_data_ff;
	assign avs_waitrequest = avs_read && !rd_ack_ff;
endmodule

// ---- cwd_config_decoder_checker.sv ----
// concurrent checks on the ports of the configuration word decoder
`timescale 1ns/100ps
module cwd_config_decoder_checker (
	input wire logic sys_clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic in_sleep, // device in sleep
	input wire logic windowed_wdt, // windowed watchdog mode
	input wire logic low_power_rc_osc_is_sysclk, // rc drives system clock
	input wire logic sw_deep_sleep_request, // software deep-sleep bit
	input wire logic [3:0] avs_address, // bus address
	input wire logic avs_write, // bus write
	input wire logic avs_chipselect_lock, // lock map select
	input wire logic avs_read, // bus read
	input wire logic avs_waitrequest, // bus wait
	input wire logic clock_switch_en, // switching allowed
	input wire logic fail_safe_monitor_en, // monitor on
	input wire logic osc_pin_clock_output, // pin gives clock
	input wire logic osc_pin_port_io, // pin is port
	input wire logic [1:0] watchdog_clock_src, // watchdog source
	input wire logic [1:0] primary_osc_mode, // oscillator mode
	input wire logic crystal_high_speed, // high-speed drive
	input wire logic [23:0] protect_lo_addr, // protected low end
	input wire logic [23:0] protect_hi_addr, // protected high end
	input wire logic [3:0] watchdog_window_eighths, // window width
	input wire logic secondary_osc_crystal, // crystal circuit
	input wire logic secondary_clock_digital_in, // digital clock in
	input wire logic usb_pll_enable, // pll running
	input wire logic [3:0] usb_pll_divisor, // pll divisor
	input wire logic usb_pll_code_reserved, // reserved code
	input wire logic deep_sleep_allowed, // deep sleep permitted
	input wire logic pin_select_lock // pin-select lock
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_switch_monitor: assert property (fail_safe_monitor_en |-> clock_switch_en)
		else $error("monitor on without clock switching");
	chk_pin_function: assert property ((primary_osc_mode inside {2'b01, 2'b10}) |->
		!osc_pin_clock_output && !osc_pin_port_io)
		else $error("osc pin function active in crystal mode");
	chk_hs_mode: assert property (crystal_high_speed ==
		(primary_osc_mode == cwd_pkg::CWD_POSC_HS))
		else $error("high-speed drive does not follow mode");
	chk_sleep_source: assert property (in_sleep |->
		watchdog_clock_src != cwd_pkg::CWD_WDCLK_SYS)
		else $error("system clock feeds watchdog in sleep");
	chk_frc_cond: assert property (watchdog_clock_src == cwd_pkg::CWD_WDCLK_FRC |->
		windowed_wdt && !low_power_rc_osc_is_sysclk && !in_sleep)
		else $error("fast rc chosen outside its condition");
	chk_window_code: assert property (watchdog_window_eighths inside
		{4'h2, 4'h3, 4'h4, 4'h6})
		else $error("window width outside the four settings");
	chk_secondary_osc_mode: assert property (secondary_osc_crystal !=
		secondary_clock_digital_in)
		else $error("secondary osc mode outputs agree");
	chk_pll_enable: assert property (usb_pll_enable |-> !usb_pll_code_reserved &&
		(usb_pll_divisor inside {[4'h1:4'h6], 4'h8, 4'hC}))
		else $error("pll enabled with bad divisor");
	chk_ds_allowed: assert property (deep_sleep_allowed |->
		sw_deep_sleep_request)
		else $error("deep sleep without software request");
	chk_decode_static: assert property ($past(nrst, 2) |->
		$stable({protect_lo_addr, protect_hi_addr, watchdog_window_eighths, primary_osc_mode,
		usb_pll_divisor}))
		else $error("decoded setting changed between resets");
	chk_lock_by_write: assert property ($changed(pin_select_lock) && $past(nrst) |->
		$past(avs_write && avs_chipselect_lock && avs_address == cwd_pkg::OFS_LOCK_CTRL))
		else $error("pin lock changed without a lock write");
	cover property (watchdog_clock_src == cwd_pkg::CWD_WDCLK_FRC);
	cover property ($rose(pin_select_lock));
	cover property (avs_read && !avs_waitrequest);
endmodule
bind cwd_config_decoder cwd_config_decoder_checker chk_u (.sys_clk, .nrst, .in_sleep, .windowed_wdt,
	.low_power_rc_osc_is_sysclk, .sw_deep_sleep_request, .avs_address, .avs_write, .avs_chipselect_lock,
	.avs_read, .avs_waitrequest, .clock_switch_en, .fail_safe_monitor_en, .osc_pin_clock_output,
	.osc_pin_port_io, .watchdog_clock_src, .primary_osc_mode, .crystal_high_speed,
	.protect_lo_addr, .protect_hi_addr, .watchdog_window_eighths, .secondary_osc_crystal,
	.secondary_clock_digital_in, .usb_pll_enable, .usb_pll_divisor, .usb_pll_code_reserved,
	.deep_sleep_allowed, .pin_select_lock);

// ---- tb_cwd_config_decoder.sv ----
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module tb_cwd_config_decoder;
	localparam logic [6:0] LP = 7'h57;
	logic sys_clk = 1'b0, nrst = 1'b0;
	logic [23:0] nv_word_two = 24'h0, nv_word_three = 24'h0, nv_word_four = 24'h0;
	logic in_sleep = 1'b0, windowed_wdt = 1'b0, low_power_rc_osc_is_sysclk = 1'b0;
	logic sw_deep_sleep_request = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_chipselect_lock = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic avs_waitrequest, clock_switch_en, fail_safe_monitor_en, osc_pin_clock_output;
	logic osc_pin_port_io, crystal_high_speed, flash_protect_en, config_page_protected;
	logic brownout_reset_en, secondary_osc_crystal, secondary_clock_digital_in, second_i2c_alt_pins;
	logic usb_pll_enable, usb_pll_code_reserved, battery_rtc_run, deep_sleep_allowed;
	logic deep_sleep_watchdog_enable, pin_select_lock;
	logic [1:0] watchdog_clock_src, primary_osc_mode;
	logic [23:0] protect_lo_addr, protect_hi_addr, ew [3];
	logic [3:0] watchdog_window_eighths, usb_pll_divisor;
	logic [31:0] seed = 32'h13FD, x;
	logic [31:0] q [$];
	int err_count = 0, n_compared = 0;
	always #2 sys_clk = ~sys_clk;
	cwd_config_decoder #(.LAST_PAGE(LP)) dut_u (.sys_clk, .nrst, .nv_word_two, .nv_word_three,
		.nv_word_four, .in_sleep, .windowed_wdt, .low_power_rc_osc_is_sysclk, .sw_deep_sleep_request,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_chipselect_lock,
		.avs_readdata, .avs_waitrequest, .clock_switch_en, .fail_safe_monitor_en,
		.osc_pin_clock_output, .osc_pin_port_io, .watchdog_clock_src, .primary_osc_mode,
		.crystal_high_speed, .flash_protect_en, .protect_lo_addr, .protect_hi_addr,
		.config_page_protected, .brownout_reset_en, .watchdog_window_eighths, .secondary_osc_crystal,
		.secondary_clock_digital_in, .second_i2c_alt_pins, .usb_pll_enable, .usb_pll_divisor,
		.usb_pll_code_reserved, .battery_rtc_run, .deep_sleep_allowed, .deep_sleep_watchdog_enable,
		.pin_select_lock);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one avalon transfer; the request is held until waitrequest is sampled low
	task automatic bus(input logic cs, input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_chipselect_lock <= cs;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
		begin
			n++;
			if (n > 20)
			begin
				err_count++;
				complete_run();
			end
			@(posedge sys_clk);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic unlock();
		bus(1'b1, 1'b1, cwd_pkg::OFS_UNLOCK, {24'h0, cwd_pkg::UNLOCK_KEY_A});
		bus(1'b1, 1'b1, cwd_pkg::OFS_UNLOCK, {24'h0, cwd_pkg::UNLOCK_KEY_B});
	endtask
	task automatic check_decode();
		logic [1:0] ws, p;
		logic [3:0] c, wn, dv;
		logic [6:0] pg;
		logic pin_mode;
		p = ew[0][1:0];
		c = ew[2][13:10];
		pg = ew[1][6:0];
		pin_mode = (p == 2'b11 || p == 2'b00);
		case (ew[0][4:3])
			2'b11: ws = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
			2'b01: ws = cwd_pkg::CWD_WDCLK_SECONDARY_OSC;
			2'b00: ws = in_sleep ? cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC : cwd_pkg::CWD_WDCLK_SYS;
			default: ws = (windowed_wdt && !low_power_rc_osc_is_sysclk && !in_sleep) ?
				cwd_pkg::CWD_WDCLK_FRC : cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
		endcase
		if (!ew[0][13])
			ws = cwd_pkg::CWD_WDCLK_LOW_POWER_RC_OSC;
		wn = ew[1][10:9] == 2'b11 ? 4'h2 : ew[1][10:9] == 2'b10 ? 4'h3 :
			ew[1][10:9] == 2'b01 ? 4'h4 : 4'h6;
		dv = c == 4'h6 ? 4'h8 : c == 4'h7 ? 4'hC : c < 4'h8 ? c + 4'h1 : 4'h1;
		check("clock_switch_en", clock_switch_en, !ew[0][7]);
		check("fail_safe_monitor_en", fail_safe_monitor_en, ew[0][7:6] == 2'b00);
		check("osc_pin_clock_output", osc_pin_clock_output, pin_mode && ew[0][5]);
		check("osc_pin_port_io", osc_pin_port_io, pin_mode && !ew[0][5]);
		check("watchdog_clock_src", watchdog_clock_src, ws);
		check("primary_osc_mode", primary_osc_mode, p);
		check("crystal_high_speed", crystal_high_speed, p == 2'b10);
		check("flash_protect_en", flash_protect_en, !ew[1][13]);
		check("protect_lo_addr", protect_lo_addr, ew[1][15] ? pg * 512 : 0);
		check("protect_hi_addr", protect_hi_addr,
			(ew[1][15] ? LP : pg) * 512 + 511);
		if (!ew[1][13])
			check("config_page_protected", config_page_protected,
				!ew[1][14] || ew[1][15] || pg == LP);
		else
			check("config_page_protected", config_page_protected, 1'b0);
		check("brownout_reset_en", brownout_reset_en, ew[1][12]);
		check("watchdog_window_eighths", watchdog_window_eighths, wn);
		check("secondary_osc_crystal", secondary_osc_crystal, ew[1][8]);
		check("secondary_clock_digital_in", secondary_clock_digital_in, !ew[1][8]);
		check("second_i2c_alt_pins", second_i2c_alt_pins, ew[2][14]);
		check("usb_pll_enable", usb_pll_enable, c < 4'h8);
		check("usb_pll_code_reserved", usb_pll_code_reserved,
			c >= 4'h8 && c != 4'hF);
		if (c != 4'hF)
			check("usb_pll_divisor", usb_pll_divisor, dv);
		check("battery_rtc_run", battery_rtc_run, ew[2][9]);
		check("deep_sleep_allowed", deep_sleep_allowed,
			ew[2][8] && sw_deep_sleep_request);
		check("deep_sleep_watchdog_enable", deep_sleep_watchdog_enable, ew[2][7]);
	endtask
	// read results are compared here, oldest expectation first
	always @(posedge sys_clk)
		if (nrst && avs_read && !avs_waitrequest)
			check("avs_readdata", avs_readdata, q.pop_front());
	initial
	begin
		repeat (50000) @(posedge sys_clk);
		err_count++;
		complete_run();
	end
	initial
	begin
		for (int r = 0; r < 10; r++)
		begin
			for (int i = 0; i < 3; i++)
			begin
				x = rnd();
				ew[i] = x[23:0];
			end
			ew[0][7:6] = r[1:0];
			ew[0][1:0] = r[1:0];
			ew[0][4:3] = r[1:0];
			ew[0][13] = (r != 5);
			ew[1][10:9] = r[1:0];
			ew[1][13] = (r == 7);
			ew[1][15:14] = r == 0 ? 2'b01 : r == 1 ? 2'b11 : ew[1][15:14];
			ew[1][6:0] = r == 0 ? LP : ew[1][6:0];
			ew[2][13:10] = r == 9 ? 4'hF : r == 8 ? 4'hA : r[3:0];
			ew[2][15] = r[0];
			@(posedge sys_clk);
			nrst <= 1'b0;
			nv_word_two <= ew[0];
			nv_word_three <= ew[1];
			nv_word_four <= ew[2];
			repeat (8) @(posedge sys_clk);
			nrst <= 1'b1;
			repeat (2) @(posedge sys_clk);
			// changed stored words must not be picked up before the next reset
			nv_word_two <= ~ew[0];
			nv_word_three <= ~ew[1];
			nv_word_four <= ~ew[2];
			for (int k = 0; k < 4; k++)
			begin
				x = k == 0 ? 32'h5 : rnd();
				@(posedge sys_clk);
				{in_sleep, windowed_wdt, low_power_rc_osc_is_sysclk, sw_deep_sleep_request} <= x[3:0];
				@(negedge sys_clk);
				@(negedge sys_clk);
				check_decode();
			end
			bus(1'b0, 1'b1, cwd_pkg::OFS_WORD_TWO, rnd());
			for (int i = 0; i < 3; i++)
			begin
				q.push_back({8'h00, cwd_pkg::FILL_UPPER, ew[i][15:0]});
				bus(1'b0, 1'b0, 4'(4 * i), 32'h0);
			end
			q.push_back(cwd_pkg::UNMAPPED_READ);
			bus(1'b1, 1'b0, 4'h8, 32'h0);
			// status before any lock write: lock bit still clear
			q.push_back({28'h0, ew[2][13] && ew[2][13:10] != 4'hF, !ew[1][13] &&
				(!ew[1][14] || ew[1][15] || ew[1][6:0] == LP), !ew[1][13], 1'b0});
			bus(1'b0, 1'b0, cwd_pkg::OFS_STATUS, 32'h0);
			bus(1'b1, 1'b1, cwd_pkg::OFS_LOCK_CTRL, 32'h1);
			@(negedge sys_clk);
			check("pin_select_lock", pin_select_lock, 1'b0);
			unlock();
			bus(1'b1, 1'b1, cwd_pkg::OFS_LOCK_CTRL, 32'h1);
			@(negedge sys_clk);
			check("pin_select_lock", pin_select_lock, 1'b1);
			unlock();
			bus(1'b1, 1'b1, cwd_pkg::OFS_LOCK_CTRL, 32'h0);
			@(negedge sys_clk);
			check("pin_select_lock", pin_select_lock, ew[2][15]);
		end
		check("pending_reads", q.size(), 0);
		complete_run();
	end
endmodule
